// ---- hbs_consts.vh ----
// Constants shared by the host access port: window offsets, mode fields, opcodes, frame layout
`ifndef HBS_CONSTS_VH
`define HBS_CONSTS_VH

// ----------------------------------------------------------------
// Window offsets seen on the low address bits in indirect mode
// ----------------------------------------------------------------
`define HBS_OFS_MODE 2'h0
`define HBS_OFS_PTR_HIGH 2'h1
`define HBS_OFS_PTR_LOW 2'h2
`define HBS_OFS_DATA 2'h3

// ----------------------------------------------------------------
// Fields of host_mode_control and its reset value
// ----------------------------------------------------------------
`define HBS_MODE_INDIRECT_BIT 0
`define HBS_MODE_AUTO_INC_BIT 1
`define HBS_MODE_RESET 8'h00
`define HBS_PTR_RESET 16'h0000

// ----------------------------------------------------------------
// Serial frame layout and opcodes
// ----------------------------------------------------------------
`define HBS_OP_WRITE 8'hF0
`define HBS_OP_READ 8'h0F
`define HBS_FRAME_BITS 6'h20
`define HBS_HEAD_BITS 6'h18

// ----------------------------------------------------------------
// Reset image of the pin synchroniser {strap, cs_n, rd_n, wr_n, addr, data}
// ----------------------------------------------------------------
`define HBS_SYNC_WIDTH 27
`define HBS_SYNC_RESET 27'h3A00000

`endif

// ---- hbs_host_model.sv ----
// Host controller model: parallel bus cycles and serial frames
`timescale 1ns/1ps

module hbs_host_model (
	input wire ref_clk,
	input wire [7:0] data_out,
	input wire data_oe_n,
	input wire miso_out,
	input wire miso_oe_n,
	output reg spi_en,
	output reg cs_n,
	output reg rd_n,
	output reg wr_n,
	output reg [14:0] addr,
	output wire [7:0] data_in
);
	reg [7:0] host_data; // Host side of the data bus
	// Device wins the bus while it drives; shared line has a pull-up
	assign data_in = data_oe_n ? host_data : data_out;
	wire miso_line = miso_oe_n ? 1'b1 : miso_out;
	initial begin
		spi_en = 1'b0;
		{cs_n, rd_n, wr_n} = 3'h7;
		addr = 15'h0000;
		host_data = 8'h00;
	end
	task tick(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Strap change; select idles high in serial mode
	task set_serial(input s);
		begin
			spi_en <= s;
			addr <= {1'b0, s, 13'h0000};
			tick(6);
		end
	endtask
	// Strobes held four clocks to clear the pin sampling
	task bus_wr(input [14:0] a, input [7:0] d);
		begin
			addr <= a;
			host_data <= d;
			{cs_n, wr_n} <= 2'h0;
			tick(4);
			wr_n <= 1'b1;
			tick(4);
			cs_n <= 1'b1;
			host_data <= ~d;
			tick(4);
		end
	endtask
	task bus_rd(input [14:0] a, output [7:0] d);
		begin
			addr <= a;
			{cs_n, rd_n} <= 2'h0;
			tick(6);
			d = data_in;
			{cs_n, rd_n} <= 2'h3;
			tick(4);
		end
	endtask
	// Frame of n bits; idle clock level cpol picks mode 0 or 3
	task frame(input [31:0] f, input integer n, input cpol, output [7:0] rx);
		integer i;
		begin
			addr[14] <= cpol;
			tick(2);
			addr[13] <= 1'b0;
			tick(4);
			for (i = 0; i < n; i = i + 1) begin
				addr[14] <= 1'b0;
				addr[12] <= f[31 - i];
				tick(4);
				rx = {rx[6:0], miso_line};
				addr[14] <= 1'b1;
				tick(4);
			end
			addr[14] <= cpol;
			tick(4);
			addr[13] <= 1'b1;
			addr[12] <= ~addr[12];
			tick(8);
		end
	endtask
endmodule // hbs_host_model

// ---- hbs_host_port.v ----
// Host access port: direct and indirect parallel bus and serial slave in front of the internal store
`timescale 1ns/1ps
`include "hbs_consts.vh"

module hbs_host_port #(
	parameter MEM_AW = 15 // Internal store address width, at most 15
) (
	input wire ref_clk,
	input wire rst,
	input wire spi_en,
	input wire cs_n,
	input wire rd_n,
	input wire wr_n,
	input wire [14:0] addr,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output wire data_oe_n,
	output reg int_n,
	input wire core_irq,
	output reg miso_out,
	output wire miso_oe_n,
	output wire [7:0] mode_state,
	output wire [15:0] pointer_state
);

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	wire [`HBS_SYNC_WIDTH-1:0] pin_raw; // Raw pin image
	reg [`HBS_SYNC_WIDTH-1:0] pin_s1; // First stage, read only by pin_s2
	reg [`HBS_SYNC_WIDTH-1:0] pin_s2; // Synchronised pins
	reg [`HBS_SYNC_WIDTH-1:0] pin_s3; // Previous synchronised value for edges

	assign pin_raw = {spi_en, cs_n, rd_n, wr_n, addr, data_in};

	// Two flip-flops ahead of any logic, a third for edge finding
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= `HBS_SYNC_RESET;
			pin_s2 <= `HBS_SYNC_RESET;
			pin_s3 <= `HBS_SYNC_RESET;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// ----------------------------------------------------------------
	// Decoded pin views
	// ----------------------------------------------------------------
	wire serial_mode; // Strap selects the serial port
	wire cs_now; // Chip select asserted now
	wire cs_prev; // Chip select asserted one cycle ago
	wire rd_now; // Read strobe asserted now
	wire rd_fall; // Read strobe just asserted under select
	wire wr_rise; // Write strobe just released under select
	wire [14:0] bus_addr; // Synchronised address
	wire [7:0] bus_data; // Synchronised write data
	wire sclk_rise; // Serial clock rising edge
	wire sclk_fall; // Serial clock falling edge
	wire ss_now; // Slave select asserted
	wire mosi_now; // Master-out level

	assign serial_mode = pin_s2[26];
	assign cs_now = ~pin_s2[25];
	assign cs_prev = ~pin_s3[25];
	assign rd_now = ~pin_s2[24];
	assign rd_fall = cs_now & ~pin_s2[24] & pin_s3[24];
	assign wr_rise = cs_prev & pin_s2[23] & ~pin_s3[23];
	assign bus_addr = pin_s2[22:8];
	assign bus_data = pin_s2[7:0];
	// A14 clock, A13 select, A12 master-out; master-in leaves on miso_out
	assign sclk_rise = pin_s2[22] & ~pin_s3[22];
	assign sclk_fall = ~pin_s2[22] & pin_s3[22];
	assign ss_now = ~pin_s2[21];
	assign mosi_now = pin_s2[20];

	// ----------------------------------------------------------------
	// Port registers and store request
	// ----------------------------------------------------------------
	reg [7:0] host_mode_control; // Mode and auto-increment control
	reg [15:0] ptr; // Indirect pointer, big-endian pair
	reg mem_en; // Store request strobe
	reg mem_we; // Store write when set
	reg [MEM_AW-1:0] mem_addr; // Store location
	reg [7:0] mem_wdata; // Store write byte
	wire [7:0] mem_rdata; // Registered store read byte
	reg bus_rd_pend; // Parallel read request issued to the store
	reg bus_rd_take; // Parallel read data now in the store output register
	reg [5:0] bit_cnt; // Serial bits received in this frame
	reg [31:0] frame; // Serial receive shifter
	reg [7:0] tx_shift; // Serial transmit shifter
	reg spi_rd_pend; // Serial read request issued to the store
	reg spi_rd_take; // Serial read data now in the store output register
	reg tx_active; // Data field of a read frame under way

	wire indirect; // Indirect parallel mode
	wire auto_inc; // Pointer auto-increment
	wire [7:0] indirect_pointer_high; // Pointer high byte view
	wire [7:0] indirect_pointer_low; // Pointer low byte view
	wire [31:0] frame_next; // Frame with the new bit appended

	assign indirect = host_mode_control[`HBS_MODE_INDIRECT_BIT];
	assign auto_inc = host_mode_control[`HBS_MODE_AUTO_INC_BIT];
	assign indirect_pointer_high = ptr[15:8];
	assign indirect_pointer_low = ptr[7:0];
	assign frame_next = {frame[30:0], mosi_now};
	assign mode_state = host_mode_control;
	assign pointer_state = ptr;

	// Bus drives data only while selected and reading in parallel mode
	assign data_oe_n = ~(~serial_mode & cs_now & rd_now);
	// Master-in stays released unless selected in serial mode
	assign miso_oe_n = ~(serial_mode & ss_now);

	// ----------------------------------------------------------------
	// Internal store
	// ----------------------------------------------------------------
	hbs_mem #(
		.AW(MEM_AW),
		.DW(8)
	) u_mem (
		.clk(ref_clk),
		.rst(rst),
		.en(mem_en),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// ----------------------------------------------------------------
	// Interrupt pin
	// ----------------------------------------------------------------
	// Core request shown active low on the host pin
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_n <= 1'b1;
		end else begin
			int_n <= ~core_irq;
		end
	end

	// ----------------------------------------------------------------
	// Access engine: parallel bus and serial frames
	// ----------------------------------------------------------------
	// One process owns the store request so the two paths never collide
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			host_mode_control <= `HBS_MODE_RESET;
			ptr <= `HBS_PTR_RESET;
			mem_en <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= {MEM_AW{1'b0}};
			mem_wdata <= 8'h00;
			bus_rd_pend <= 1'b0;
			bus_rd_take <= 1'b0;
			data_out <= 8'h00;
			bit_cnt <= 6'h00;
			frame <= 32'h00000000;
			tx_shift <= 8'h00;
			spi_rd_pend <= 1'b0;
			spi_rd_take <= 1'b0;
			tx_active <= 1'b0;
			miso_out <= 1'b0;
		end else begin
			mem_en <= 1'b0;
			mem_we <= 1'b0;
			// Store output register loads one edge after the request, so wait one more
			if (bus_rd_pend) begin
				bus_rd_pend <= 1'b0;
				bus_rd_take <= 1'b1;
			end
			// Store data returned for a parallel read
			if (bus_rd_take) begin
				bus_rd_take <= 1'b0;
				data_out <= mem_rdata;
			end
			// Same one-edge wait on the serial path
			if (spi_rd_pend) begin
				spi_rd_pend <= 1'b0;
				spi_rd_take <= 1'b1;
			end
			// Store data returned for a serial read
			if (spi_rd_take) begin
				spi_rd_take <= 1'b0;
				tx_shift <= mem_rdata;
				tx_active <= 1'b1;
			end
			if (!serial_mode) begin
				// Parallel read on the falling read strobe
				if (rd_fall) begin
					if (indirect) begin
						case (bus_addr[1:0])
						`HBS_OFS_MODE: begin
							data_out <= host_mode_control;
						end
						`HBS_OFS_PTR_HIGH: begin
							data_out <= indirect_pointer_high;
						end
						`HBS_OFS_PTR_LOW: begin
							data_out <= indirect_pointer_low;
						end
						default: begin
							// Data window reads the pointed location
							mem_en <= 1'b1;
							mem_addr <= ptr[MEM_AW-1:0];
							bus_rd_pend <= 1'b1;
							if (auto_inc) begin
								ptr <= ptr + 16'h0001;
							end
						end
						endcase
					end else if (bus_addr == 15'h0000) begin
						data_out <= host_mode_control;
					end else begin
						// Direct read of any internal location except 0, which reads host_mode_control
						mem_en <= 1'b1;
						mem_addr <= bus_addr[MEM_AW-1:0];
						bus_rd_pend <= 1'b1;
					end
				end
				// Parallel write on the rising write strobe
				if (wr_rise) begin
					if (indirect) begin
						case (bus_addr[1:0])
						`HBS_OFS_MODE: begin
							host_mode_control <= bus_data;
						end
						`HBS_OFS_PTR_HIGH: begin
							ptr[15:8] <= bus_data;
						end
						`HBS_OFS_PTR_LOW: begin
							ptr[7:0] <= bus_data;
						end
						default: begin
							// Data window writes the pointed location
							mem_en <= 1'b1;
							mem_we <= 1'b1;
							mem_addr <= ptr[MEM_AW-1:0];
							mem_wdata <= bus_data;
							if (auto_inc) begin
								ptr <= ptr + 16'h0001;
							end
						end
						endcase
					end else if (bus_addr == 15'h0000) begin
						host_mode_control <= bus_data;
					end else begin
						mem_en <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= bus_addr[MEM_AW-1:0];
						mem_wdata <= bus_data;
					end
				end
			end
			// Serial frame handling, select released aborts the frame
			if (!serial_mode || !ss_now) begin
				bit_cnt <= 6'h00;
				tx_active <= 1'b0;
				miso_out <= 1'b0;
			end else begin
				// Sample master-out on the rising clock edge
				if (sclk_rise && bit_cnt != `HBS_FRAME_BITS) begin
					frame <= frame_next;
					bit_cnt <= bit_cnt + 6'h01;
					// Opcode and address complete: start a read
					if (bit_cnt == `HBS_HEAD_BITS - 6'h01 && frame_next[23:16] == `HBS_OP_READ) begin
						mem_en <= 1'b1;
						mem_addr <= frame_next[MEM_AW-1:0];
						spi_rd_pend <= 1'b1;
					end
					// Last bit in: store the byte of a write frame
					if (bit_cnt == `HBS_FRAME_BITS - 6'h01 && frame_next[31:24] == `HBS_OP_WRITE) begin
						mem_en <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= frame_next[MEM_AW+7:8];
						mem_wdata <= frame_next[7:0];
					end
				end
				// Change master-in on the falling clock edge
				if (sclk_fall && tx_active && bit_cnt >= `HBS_HEAD_BITS) begin
					miso_out <= tx_shift[7];
					tx_shift <= {tx_shift[6:0], 1'b0};
				end
			end
		end
	end

endmodule // hbs_host_port

// ---- hbs_host_port_monitor.sv ----
// Pin checker for the host access port
`timescale 1ns/1ps

module hbs_host_port_monitor #(
	parameter MEM_AW = 15 // Store address width
) (
	input wire ref_clk,
	input wire rst,
	input wire spi_en,
	input wire cs_n,
	input wire rd_n,
	input wire wr_n,
	input wire [14:0] addr,
	input wire [7:0] data_in,
	input wire [7:0] data_out,
	input wire data_oe_n,
	input wire int_n,
	input wire core_irq,
	input wire miso_out,
	input wire miso_oe_n,
	input wire [7:0] mode_state,
	input wire [15:0] pointer_state
);
	// ----------------
	// Pin relations
	// ----------------
	default clocking hbs_cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	a_irq_low: assert property ($rose(core_irq) |=> !int_n) else $error("int_n missed");
	a_irq_high: assert property ($fell(core_irq) |=> int_n) else $error("int_n stuck");
	a_bus_drive: assert property ((!spi_en && !cs_n && !rd_n) [*4] |-> !data_oe_n) else $error("no drive");
	a_bus_release: assert property ((cs_n || rd_n || spi_en) [*4] |-> data_oe_n) else $error("bus held");
	a_miso_drive: assert property ((spi_en && !addr[13]) [*4] |-> !miso_oe_n) else $error("miso idle");
	a_miso_release: assert property ((!spi_en || addr[13]) [*4] |-> miso_oe_n) else $error("miso held");
	a_miso_steady: assert property ($rose(addr[14]) && spi_en && !addr[13] |=> $stable(miso_out) [*4])
		else $error("miso moved");
	a_serial_locks: assert property (spi_en [*4] |=> $stable(pointer_state) && $stable(mode_state))
		else $error("state moved");
	// Main scenarios reached
	c_serial_out: cover property (!miso_oe_n && $fell(addr[14]));
	c_bus_read: cover property (!data_oe_n);
	c_auto_inc: cover property ($changed(pointer_state) && mode_state[1]);
endmodule // hbs_host_port_monitor

bind hbs_host_port hbs_host_port_monitor #(.MEM_AW(MEM_AW)) hbs_mon (.ref_clk(ref_clk), .rst(rst),
	.spi_en(spi_en), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
	.data_out(data_out), .data_oe_n(data_oe_n), .int_n(int_n), .core_irq(core_irq), .miso_out(miso_out),
	.miso_oe_n(miso_oe_n), .mode_state(mode_state), .pointer_state(pointer_state));

// ---- hbs_mem.v ----
// Internal register and buffer store with a registered read port
`timescale 1ns/1ps

module hbs_mem #(
	parameter AW = 15, // Address width
	parameter DW = 8 // Data width
) (
	input wire clk,
	input wire rst,
	input wire en,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg [DW-1:0] rdata
);

	// ----------------------------------------------------------------
	// Storage array
	// ----------------------------------------------------------------
	reg [DW-1:0] store [0:(1<<AW)-1]; // Location array, no reset

	// Write port
	always @(posedge clk) begin
		if (en && we) begin
			store[addr] <= wdata;
		end
	end

	// Registered read port, valid one cycle after the request
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= {DW{1'b0}};
		end else if (en && !we) begin
			rdata <= store[addr];
		end
	end

endmodule // hbs_mem

// ---- test_host_bus_and_spi_slave_port.sv ----
// Self-checking bench of the host access port
`timescale 1ns/1ps
`include "hbs_consts.vh"

module test_host_bus_and_spi_slave_port;
	reg ref_clk;
	reg rst;
	reg core_irq;
	wire [14:0] addr;
	wire [7:0] data_in, data_out, mode_state;
	wire [15:0] pointer_state;
	wire data_oe_n, int_n, miso_out, miso_oe_n, spi_en, cs_n, rd_n, wr_n;
	integer bad_count = 0;
	integer total_checks = 0;
	integer cycles = 0;
	integer i;
	reg [31:0] seed = 32'h00000020; // LFSR start
	reg [7:0] r, d;
	reg [14:0] a;
	reg [15:0] p;
	hbs_host_port #(.MEM_AW(15)) uut (.ref_clk(ref_clk), .rst(rst), .spi_en(spi_en), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .int_n(int_n),
		.core_irq(core_irq), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .mode_state(mode_state),
		.pointer_state(pointer_state));
	hbs_host_model host (.ref_clk(ref_clk), .data_out(data_out), .data_oe_n(data_oe_n), .miso_out(miso_out),
		.miso_oe_n(miso_oe_n), .spi_en(spi_en), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
		.data_in(data_in));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check(input [15:0] seen, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", total_checks, bad_count);
			if (bad_count == 0 && total_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Hang guard
	always @(posedge ref_clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			bad_count = bad_count + 1;
			print_verdict;
		end
	end
	initial begin
		rst = 1'b1;
		core_irq = 1'b0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		host.tick(4);
		check(mode_state, `HBS_MODE_RESET);
		check(pointer_state, `HBS_PTR_RESET);
		core_irq <= 1'b1;
		host.tick(2);
		check(int_n, 1'b0);
		core_irq <= 1'b0;
		host.tick(2);
		check(int_n, 1'b1);
		for (i = 0; i < 8; i = i + 1) begin
			seed = lfsr(seed);
			core_irq <= seed[0];
			host.tick(2);
			check(int_n, !seed[0]);
		end
		core_irq <= 1'b0;
		host.tick(2);
		$display("test reset done");
		for (i = 0; i < 4; i = i + 1) begin
			seed = lfsr(seed);
			a = seed[14:0] | 15'h0100;
			host.bus_wr(a, seed[22:15]);
			host.bus_rd(a, r);
			check(r, seed[22:15]);
		end
		$display("test direct done");
		p = (seed[31:16] & 16'h7FF0) | 16'h0100;
		host.bus_wr(15'h0000, 8'h03);
		check(mode_state, 8'h03);
		host.bus_wr(15'h0001, p[15:8]);
		host.bus_wr(15'h0002, p[7:0]);
		check(pointer_state, p);
		for (i = 0; i < 3; i = i + 1)
			host.bus_wr(15'h0003, p[7:0] + i[7:0]);
		check(pointer_state, p + 16'h0003);
		host.bus_wr(15'h0002, p[7:0]);
		for (i = 0; i < 3; i = i + 1) begin
			host.bus_rd(15'h0003, r);
			check(r, p[7:0] + i[7:0]);
		end
		host.bus_wr(15'h0000, 8'h01);
		host.bus_rd(15'h0003, r);
		check(pointer_state, p + 16'h0003);
		host.bus_wr(15'h0000, 8'h00);
		host.bus_rd(p[14:0], r);
		check(r, p[7:0]);
		$display("test indirect done");
		rst <= 1'b1;
		host.tick(3);
		check(pointer_state, `HBS_PTR_RESET);
		check(data_out, 8'h00);
		rst <= 1'b0;
		host.tick(4);
		check(mode_state, `HBS_MODE_RESET);
		check(int_n, 1'b1);
		$display("test mid reset done");
		host.set_serial(1'b1);
		seed = lfsr(seed);
		a = seed[14:0] | 15'h0100;
		d = seed[22:15];
		host.frame({`HBS_OP_WRITE, 1'b0, a, d}, 32, 1'b0, r);
		host.frame({`HBS_OP_READ, 1'b0, a, 8'h00}, 32, 1'b0, r);
		check(r, d);
		host.frame({`HBS_OP_READ, 1'b0, a, 8'h00}, 32, 1'b1, r);
		check(r, d);
		p = 16'h00FF;
		for (i = 0; i < 4; i = i + 1)
			host.frame({i[1] ? p[15:8] : p[7:0] ^ {4{i[0], 1'b1}}, 1'b0, a, ~d}, 32, i[0], r);
		host.frame({`HBS_OP_READ, 1'b0, a, 8'h00}, 32, 1'b0, r);
		check(r, d);
		host.frame({`HBS_OP_WRITE, 1'b0, a, ~d}, 28, 1'b0, r);
		host.frame({`HBS_OP_READ, 1'b0, a, 8'h00}, 32, 1'b0, r);
		check(r, d);
		check(miso_oe_n, 1'b1);
		host.set_serial(1'b0);
		host.bus_rd(a, r);
		check(r, d);
		$display("test serial done");
		print_verdict;
	end
endmodule // test_host_bus_and_spi_slave_port
